// >>> src/rdac_pkg.sv
// Purpose: Shared constants for the dual alarm compare block.
// Assumes: APB with 32-bit data; register indices multiplied by four give byte addresses.
// Notes: Offsets are word indices because the printed offsets are not multiples of four.
package rdac_pkg;
  localparam int unsigned RDAC_NREG = 16;
  // Register indices.
  localparam logic [7:0] IDX_A1_WEEKDAY = 8'h11;
  localparam logic [7:0] IDX_A1_MONTH = 8'h12;
  localparam logic [7:0] IDX_A1_YEAR = 8'h13;
  localparam logic [7:0] IDX_A1_MONTHDAY = 8'h14;
  localparam logic [7:0] IDX_A2_SECOND = 8'h15;
  localparam logic [7:0] IDX_A2_MINUTE = 8'h16;
  localparam logic [7:0] IDX_A2_HOUR = 8'h17;
  localparam logic [7:0] IDX_A2_WEEKDAY = 8'h18;
  localparam logic [7:0] IDX_A2_MONTH = 8'h19;
  localparam logic [7:0] IDX_A2_YEAR = 8'h1a;
  localparam logic [7:0] IDX_A2_MONTHDAY = 8'h1b;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h1c;
  localparam logic [7:0] IDX_IRQ_ENABLE = 8'h1d;
  localparam logic [7:0] IDX_IRQ_CLEAR = 8'h1e;
  localparam logic [7:0] IDX_MODE = 8'h1f;
  localparam logic [7:0] IDX_FIRST = 8'h11;
  // Reset values.
  localparam logic [7:0] RST_WEEKDAY = 8'h01;
  localparam logic [7:0] RST_A2_MINUTE = 8'h01;
  localparam logic [7:0] RST_ZERO = 8'h00;
  // Field layout.
  localparam int unsigned BIT_ENABLE = 7;
  localparam int unsigned BIT_MERIDIEM = 6;
  // Storage masks: reserved positions have no flip-flop.
  localparam logic [7:0] MASK_FULL = 8'hff;
  localparam logic [7:0] MASK_MONTH = 8'h9f;
  localparam logic [7:0] MASK_MONTHDAY = 8'hbf;
  localparam logic [7:0] MASK_MODE = 8'h01;
  localparam logic [7:0] MASK_IRQ = 8'h03;
endpackage

// >>> src/rdac_regfile.sv
// Purpose: Small register array for alarm targets with a registered read port.
// Assumes: One write and one read per cycle, clock enable freezes all state.
// Notes: Reset values come in as a parameter vector so the array stays generic.
`timescale 1ns/1ps
module rdac_regfile #(
  parameter int unsigned NREG = 16,
  parameter logic [8*16-1:0] RESET_VALUES = '0,
  parameter logic [8*16-1:0] STORE_MASKS = '1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic wr_en,
  input wire logic [3:0] wr_idx,
  input wire logic [7:0] wr_data,
  input wire logic [3:0] rd_idx,
  output logic [7:0] rd_data,
  output logic [8*NREG-1:0] all_regs
);
  typedef struct packed {
    logic [8*NREG-1:0] regs;
    logic [7:0] rd;
  } rdac_rf_s;
  rdac_rf_s st;
  rdac_rf_s next_st;

  always_comb begin
    next_st = st;
    if (wr_en) begin
      next_st.regs[wr_idx*8 +: 8] = wr_data & STORE_MASKS[wr_idx*8 +: 8];
    end
    next_st.rd = st.regs[rd_idx*8 +: 8];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '{regs: RESET_VALUES[8*NREG-1:0], rd: 8'h00};
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  assign rd_data = st.rd;
  assign all_regs = st.regs;
endmodule

// >>> src/rdac_top.sv
// Purpose: Two real-time-clock alarms compared against the running calendar.
// Assumes: Calendar counters are synchronous to pclk; APB slave, writes and status reads without wait states.
// Assumes: Reads of the target array take one wait state because the array read port is registered.
// Notes: Each alarm fires on the cycle after its enabled fields first all match.
// How it works
// - Bit 7 of each target register enables that field in matching.
// - Alarm one fires on weekday match when its weekday enable is set.
// - Alarm one fires on six-bit day-of-month match when enabled.
// - Alarm two fires on seven-bit minute match when minute enable is set.
// - Alarm two fires on six-bit hour match when hour enable is set.
// - Alarm two fires on weekday match when its weekday enable is set.
// - Alarm two fires on year match when its year enable is set.
// - Alarm two fires on day-of-month match when enabled.
// - Weekday targets are one-hot, bit 6 Saturday down to bit 0 Sunday.
// - Hour meridiem bit compared only in 12-hour mode, one meaning PM.
// - Reserved bits have no storage and read as zero.
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
module rdac_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [6:0] seconds_counter,
  input wire logic [6:0] minute_counter,
  input wire logic [5:0] hour_counter,
  input wire logic meridiem_flag,
  input wire logic [6:0] weekday_counter,
  input wire logic [4:0] month_counter,
  input wire logic [7:0] year_counter,
  input wire logic [5:0] monthday_counter,
  input wire logic twentyfour_hour_select,
  output logic first_alarm_irq,
  output logic second_alarm_irq,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // Register map helpers.

  // Slot 15 stands first in each table, slot 0 last; slot n holds register index 0x11 + n.
  localparam logic [8*16-1:0] RF_RESET = {
    rdac_pkg::RST_ZERO,
    rdac_pkg::RST_ZERO,
    rdac_pkg::RST_ZERO,
    rdac_pkg::RST_ZERO,
    rdac_pkg::RST_ZERO,
    rdac_pkg::RST_ZERO,
    rdac_pkg::RST_ZERO,
    rdac_pkg::RST_ZERO,
    rdac_pkg::RST_WEEKDAY,
    rdac_pkg::RST_ZERO,
    rdac_pkg::RST_A2_MINUTE,
    rdac_pkg::RST_ZERO,
    rdac_pkg::RST_ZERO,
    rdac_pkg::RST_ZERO,
    rdac_pkg::RST_ZERO,
    rdac_pkg::RST_WEEKDAY};
  // Slots 11 to 14 are served outside the array, so they keep no bits here.
  localparam logic [8*16-1:0] RF_MASK = {
    rdac_pkg::MASK_MODE,
    8'h00,
    8'h00,
    8'h00,
    8'h00,
    rdac_pkg::MASK_MONTHDAY,
    rdac_pkg::MASK_FULL,
    rdac_pkg::MASK_MONTH,
    rdac_pkg::MASK_FULL,
    rdac_pkg::MASK_FULL,
    rdac_pkg::MASK_FULL,
    rdac_pkg::MASK_FULL,
    rdac_pkg::MASK_MONTHDAY,
    rdac_pkg::MASK_FULL,
    rdac_pkg::MASK_MONTH,
    rdac_pkg::MASK_FULL};

  // Slot of a register index inside the array; also flags an unmapped address.
  function automatic logic [4:0] rdac_slot(input logic [31:0] addr);
    logic [7:0] idx;
    idx = addr[9:2];
    if (addr[1:0] != 2'b00 || addr[31:10] != 22'h0) begin
      rdac_slot = 5'h10;
    end else if (idx >= rdac_pkg::IDX_FIRST && idx <= rdac_pkg::IDX_MODE) begin
      rdac_slot = {1'b0, 4'(idx - rdac_pkg::IDX_FIRST)};
    end else begin
      rdac_slot = 5'h10;
    end
  endfunction

  // A field takes part when its enable is set; a disabled field always counts as matched.
  function automatic logic rdac_field_ok(input logic en, input logic eq);
    rdac_field_ok = !en || eq;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // State.

  typedef struct packed {
    logic [1:0] status;
    logic [1:0] enable;
    logic [1:0] match_prev;
    logic rd_pending;
    logic rd_status;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic first_irq;
    logic second_irq;
    logic irq;
  } rdac_state_s;

  rdac_state_s st;
  rdac_state_s next_st;

  logic [4:0] slot;
  logic setup;
  logic commit;
  logic arr_slot;
  logic rf_wr;
  logic [7:0] rf_rd;
  logic [8*16-1:0] regs;

  assign slot = rdac_slot(paddr);
  assign setup = psel && !penable;
  // Writes land only at the edge that completes the transfer, so an aborted setup changes nothing.
  assign commit = psel && penable && st.pready;
  assign arr_slot = !slot[4] && slot[3:0] <= 4'(rdac_pkg::IDX_A2_MONTHDAY - rdac_pkg::IDX_FIRST);
  assign rf_wr = commit && pwrite && arr_slot;

  rdac_regfile #(
    .NREG(16),
    .RESET_VALUES(RF_RESET),
    .STORE_MASKS(RF_MASK)
  ) u_regs (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .wr_en(rf_wr),
    .wr_idx(slot[3:0]),
    .wr_data(pwdata[7:0]),
    .rd_idx(slot[3:0]),
    .rd_data(rf_rd),
    .all_regs(regs)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Target fields.

  function automatic logic [7:0] rdac_reg(input logic [8*16-1:0] r, input logic [7:0] idx);
    rdac_reg = r[(idx - rdac_pkg::IDX_FIRST)*8 +: 8];
  endfunction

  logic [7:0] a1_wday, a1_mon, a1_year, a1_mday;
  logic [7:0] a2_sec, a2_min, a2_hour, a2_wday, a2_mon, a2_year, a2_mday;
  logic twelve_hour;
  logic meridiem_ok;
  logic [1:0] match_now;

  assign a1_wday = rdac_reg(regs, rdac_pkg::IDX_A1_WEEKDAY);
  assign a1_mon = rdac_reg(regs, rdac_pkg::IDX_A1_MONTH);
  assign a1_year = rdac_reg(regs, rdac_pkg::IDX_A1_YEAR);
  assign a1_mday = rdac_reg(regs, rdac_pkg::IDX_A1_MONTHDAY);
  assign a2_sec = rdac_reg(regs, rdac_pkg::IDX_A2_SECOND);
  assign a2_min = rdac_reg(regs, rdac_pkg::IDX_A2_MINUTE);
  assign a2_hour = rdac_reg(regs, rdac_pkg::IDX_A2_HOUR);
  assign a2_wday = rdac_reg(regs, rdac_pkg::IDX_A2_WEEKDAY);
  assign a2_mon = rdac_reg(regs, rdac_pkg::IDX_A2_MONTH);
  assign a2_year = rdac_reg(regs, rdac_pkg::IDX_A2_YEAR);
  assign a2_mday = rdac_reg(regs, rdac_pkg::IDX_A2_MONTHDAY);

  assign twelve_hour = !twentyfour_hour_select;
  // The meridiem bit is a don't care in 24-hour mode.
  assign meridiem_ok = !twelve_hour || (a2_hour[rdac_pkg::BIT_MERIDIEM] == meridiem_flag);

  always_comb begin
    // The weekday is compared as the whole one-hot pattern, bit 6 Saturday to bit 0 Sunday.
    match_now[0] = rdac_field_ok(a1_wday[rdac_pkg::BIT_ENABLE], a1_wday[6:0] == weekday_counter)
      && rdac_field_ok(a1_mon[rdac_pkg::BIT_ENABLE], a1_mon[4:0] == month_counter)
      && rdac_field_ok(a1_year[rdac_pkg::BIT_ENABLE], a1_year[6:0] == year_counter[6:0])
      && rdac_field_ok(a1_mday[rdac_pkg::BIT_ENABLE], a1_mday[5:0] == monthday_counter)
      && (a1_wday[rdac_pkg::BIT_ENABLE] || a1_mon[rdac_pkg::BIT_ENABLE]
          || a1_year[rdac_pkg::BIT_ENABLE] || a1_mday[rdac_pkg::BIT_ENABLE]);
    match_now[1] = rdac_field_ok(a2_sec[rdac_pkg::BIT_ENABLE], a2_sec[6:0] == seconds_counter)
      && rdac_field_ok(a2_min[rdac_pkg::BIT_ENABLE], a2_min[6:0] == minute_counter)
      && rdac_field_ok(a2_hour[rdac_pkg::BIT_ENABLE],
                       a2_hour[5:0] == hour_counter && meridiem_ok)
      && rdac_field_ok(a2_wday[rdac_pkg::BIT_ENABLE], a2_wday[6:0] == weekday_counter)
      && rdac_field_ok(a2_mon[rdac_pkg::BIT_ENABLE], a2_mon[4:0] == month_counter)
      && rdac_field_ok(a2_year[rdac_pkg::BIT_ENABLE], a2_year[6:0] == year_counter[6:0])
      && rdac_field_ok(a2_mday[rdac_pkg::BIT_ENABLE], a2_mday[5:0] == monthday_counter)
      && (a2_sec[rdac_pkg::BIT_ENABLE] || a2_min[rdac_pkg::BIT_ENABLE] || a2_hour[rdac_pkg::BIT_ENABLE]
          || a2_wday[rdac_pkg::BIT_ENABLE] || a2_mon[rdac_pkg::BIT_ENABLE]
          || a2_year[rdac_pkg::BIT_ENABLE] || a2_mday[rdac_pkg::BIT_ENABLE]);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Events, bus answer and outputs.

  logic [1:0] rise;
  logic [1:0] clr;
  logic [1:0] next_status;
  logic [31:0] direct_rd;

  assign rise = match_now & ~st.match_prev;
  assign clr = (commit && pwrite && slot == 5'(rdac_pkg::IDX_IRQ_CLEAR - rdac_pkg::IDX_FIRST))
               ? pwdata[1:0] : 2'b00;
  // A new match in the clearing cycle wins, so no alarm is lost.
  assign next_status = (st.status & ~clr) | rise;

  always_comb begin
    if (slot == 5'(rdac_pkg::IDX_IRQ_STATUS - rdac_pkg::IDX_FIRST)) begin
      direct_rd = {30'h0, st.status};
    end else if (slot == 5'(rdac_pkg::IDX_IRQ_ENABLE - rdac_pkg::IDX_FIRST)) begin
      direct_rd = {30'h0, st.enable};
    end else begin
      direct_rd = 32'h0;
    end
  end

  always_comb begin
    next_st = st;
    next_st.match_prev = match_now;
    next_st.status = next_status;
    if (commit && pwrite && slot == 5'(rdac_pkg::IDX_IRQ_ENABLE - rdac_pkg::IDX_FIRST)) begin
      next_st.enable = pwdata[1:0] & rdac_pkg::MASK_IRQ[1:0];
    end
    // The array port is registered, so a target read answers one cycle later than the others.
    next_st.rd_pending = setup && !pwrite && arr_slot;
    next_st.rd_status = setup && (slot >= 5'(rdac_pkg::IDX_IRQ_STATUS - rdac_pkg::IDX_FIRST));
    next_st.pready = (setup && !(!pwrite && arr_slot)) || st.rd_pending;
    next_st.pslverr = setup && slot[4];
    if (setup) begin
      next_st.prdata = direct_rd;
    end else if (st.rd_pending && !st.rd_status) begin
      next_st.prdata = {24'h0, rf_rd};
    end
    if (st.pready) begin
      next_st.pready = 1'b0;
      next_st.pslverr = 1'b0;
    end
    next_st.first_irq = next_status[0];
    next_st.second_irq = next_status[1];
    next_st.irq = |(next_status & st.enable);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  // Read data is valid together with pready.
  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign first_alarm_irq = st.first_irq;
  assign second_alarm_irq = st.second_irq;
  assign irq = st.irq;
endmodule

// >>> dv/rdac_asserts.sv
// Purpose: Port-level checks of the dual alarm compare block.
// Assumes: APB answers within two cycles of setup and sticky alarm outputs.
// Notes: Targets are hidden here, so alarm checks cover stickiness and masking only.
`timescale 1ns/1ps
module rdac_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic first_alarm_irq,
  input wire logic second_alarm_irq,
  input wire logic irq
);
  logic setup;
  logic clr_hit;
  logic rd_done;
  assign setup = psel && !penable && clk_en;
  assign clr_hit = psel && penable && pready && clk_en && pwrite && paddr[9:2] == rdac_pkg::IDX_IRQ_CLEAR;
  assign rd_done = pready && !pwrite;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////
  a_answer_after_setup: assert property (setup |-> ##[1:2] pready)
    else $error("setup not answered");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_err_unmapped: assert property (setup && paddr < 32'h44 |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_upper_read_zero: assert property (rd_done |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_month_rsvd_zero: assert property (rd_done && paddr[9:2] == rdac_pkg::IDX_A1_MONTH |-> prdata[6:5] == 2'h0)
    else $error("month reserved bits set");
  a_mday_rsvd_zero: assert property (rd_done && paddr[9:2] == rdac_pkg::IDX_A1_MONTHDAY |-> !prdata[6])
    else $error("monthday reserved bit set");
  a_first_sticky: assert property (first_alarm_irq && !(clr_hit && pwdata[0]) |=> first_alarm_irq)
    else $error("first alarm dropped without clear");
  a_second_sticky: assert property (second_alarm_irq && !(clr_hit && pwdata[1]) |=> second_alarm_irq)
    else $error("second alarm dropped without clear");
  a_irq_has_source: assert property (irq |-> first_alarm_irq || second_alarm_irq)
    else $error("interrupt without alarm");
endmodule
bind rdac_top rdac_asserts rdac_asserts_i (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .first_alarm_irq, .second_alarm_irq, .irq);

// >>> dv/test_rdac_top.sv
// Purpose: Self-checking bench for the dual alarm compare block.
// Assumes: Status sets within three cycles of a match.
// Notes: Counters are driven directly since the running calendar lives outside the block.
`timescale 1ns/1ps
module test_rdac_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic clk_en = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rdat;
  logic pready, pslverr, first_alarm_irq, second_alarm_irq, irq, rerr;
  logic [6:0] seconds_counter = 7'h0;
  logic [6:0] minute_counter = 7'h0;
  logic [5:0] hour_counter = 6'h0;
  logic meridiem_flag = 1'b0;
  logic [6:0] weekday_counter = 7'h0;
  logic [4:0] month_counter = 5'h0;
  logic [7:0] year_counter = 8'h0;
  logic [5:0] monthday_counter = 6'h0;
  logic twentyfour_hour_select = 1'b1;
  logic [1:0] en = 2'h0;
  int err_count = 0;
  int check_count = 0;
  always #20 pclk = ~pclk;
  rdac_top rdac_top_i (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .seconds_counter, .minute_counter, .hour_counter, .meridiem_flag, .weekday_counter, .month_counter,
    .year_counter, .monthday_counter, .twentyfour_hour_select, .first_alarm_irq, .second_alarm_irq, .irq);
  ////////////////////////////////////////////////////////////////
  task chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", n, exp, got);
    end
  endtask
  // Entered just after a rising edge; returns on one after an idle cycle with psel low, so calls chain with a one-cycle gap.
  task apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {22'h0, idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) err_count++;
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task settle(input logic [1:0] e);
    repeat (3) @(posedge pclk);
    chk("first_irq", 32'(first_alarm_irq), 32'(e[0]));
    chk("second_irq", 32'(second_alarm_irq), 32'(e[1]));
    chk("irq", 32'(irq), 32'(|(e & en)));
    apb(1'b0, rdac_pkg::IDX_IRQ_STATUS, 32'h0);
    chk("status", rdat, 32'(e));
    apb(1'b1, rdac_pkg::IDX_IRQ_CLEAR, 32'h3);
    chk("irq_clear", 32'(irq), 32'h0);
  endtask
  task arm(input logic [7:0] idx, input logic [7:0] v);
    apb(1'b1, idx, 32'(v));
    settle(2'h0);
  endtask
  ////////////////////////////////////////////////////////////////
  task t_reset;
    apb(1'b0, rdac_pkg::IDX_A1_WEEKDAY, 32'h0);
    chk("a1_wday", rdat, 32'h1);
    apb(1'b0, rdac_pkg::IDX_A2_MINUTE, 32'h0);
    chk("a2_min", rdat, 32'h1);
    apb(1'b0, rdac_pkg::IDX_A2_WEEKDAY, 32'h0);
    chk("a2_wday", rdat, 32'h1);
    apb(1'b0, 8'h05, 32'h0);
    chk("slverr", 32'(rerr), 32'h1);
  endtask
  task t_rsvd;
    apb(1'b1, rdac_pkg::IDX_A1_MONTH, 32'hff);
    apb(1'b0, rdac_pkg::IDX_A1_MONTH, 32'h0);
    chk("a1_month", rdat, 32'h9f);
    apb(1'b1, rdac_pkg::IDX_A1_MONTHDAY, 32'hff);
    apb(1'b0, rdac_pkg::IDX_A1_MONTHDAY, 32'h0);
    chk("a1_mday", rdat, 32'hbf);
    apb(1'b1, rdac_pkg::IDX_A1_MONTH, 32'h0);
    apb(1'b1, rdac_pkg::IDX_A1_MONTHDAY, 32'h0);
  endtask
  task t_alarm1;
    en = 2'h3;
    apb(1'b1, rdac_pkg::IDX_IRQ_ENABLE, 32'h3);
    apb(1'b0, rdac_pkg::IDX_IRQ_ENABLE, 32'h0);
    chk("enable", rdat, 32'h3);
    for (int k = 0; k < 7; k++) begin
      arm(rdac_pkg::IDX_A1_WEEKDAY, 8'h80 | (8'h1 << k));
      weekday_counter <= 7'h1 << k;
      settle(2'h1);
    end
    arm(rdac_pkg::IDX_A1_MONTH, 8'h8c);
    month_counter <= 5'h0c;
    settle(2'h1);
    arm(rdac_pkg::IDX_A1_MONTHDAY, 8'h9f);
    monthday_counter <= 6'h1f;
    settle(2'h1);
    // Weekday disabled on a different day must no longer hold the alarm back.
    arm(rdac_pkg::IDX_A1_WEEKDAY, 8'h01);
    monthday_counter <= 6'h00;
    settle(2'h0);
    monthday_counter <= 6'h1f;
    settle(2'h1);
    apb(1'b1, rdac_pkg::IDX_A1_MONTH, 32'h0c);
    arm(rdac_pkg::IDX_A1_MONTHDAY, 8'h1f);
  endtask
  task t_alarm2;
    en = 2'h1;
    apb(1'b1, rdac_pkg::IDX_IRQ_ENABLE, 32'h1);
    arm(rdac_pkg::IDX_A2_MINUTE, 8'hbb);
    minute_counter <= 7'h3b;
    settle(2'h2);
    en = 2'h3;
    apb(1'b1, rdac_pkg::IDX_IRQ_ENABLE, 32'h3);
    arm(rdac_pkg::IDX_A2_HOUR, 8'hd7);
    hour_counter <= 6'h17;
    settle(2'h2);
    arm(rdac_pkg::IDX_A2_WEEKDAY, 8'ha0);
    weekday_counter <= 7'h20;
    settle(2'h2);
    arm(rdac_pkg::IDX_A2_YEAR, 8'he3);
    year_counter <= 8'h63;
    settle(2'h2);
    arm(rdac_pkg::IDX_A2_MONTHDAY, 8'h9c);
    monthday_counter <= 6'h1c;
    settle(2'h2);
    twentyfour_hour_select <= 1'b0;
    arm(rdac_pkg::IDX_A2_HOUR, 8'hcc);
    hour_counter <= 6'h0c;
    settle(2'h0);
    meridiem_flag <= 1'b1;
    settle(2'h2);
  endtask
  ////////////////////////////////////////////////////////////////
  task give_verdict;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_rsvd;
    t_alarm1;
    t_alarm2;
    give_verdict;
  end
  // The whole run needs well under two thousand cycles.
  initial begin
    #200000;
    err_count++;
    give_verdict;
  end
endmodule
